//--- shared/hmc_pkg.sv
// Package with register map, field positions, reset values and carrier types of the mode block.
package hmc_pkg;

	// ==========================================================
	// Register map.
	localparam logic [11:0] HMC_ADDR_MODE = 12'h0300;
	localparam logic [11:0] HMC_ADDR_IRQ_STATUS = 12'h0310;
	localparam logic [11:0] HMC_ADDR_IRQ_MASK = 12'h0314;
	localparam logic [11:0] HMC_ADDR_STATE = 12'h0318;

	// ==========================================================
	// Mode register fields.
	localparam int HMC_BIT_XCVR_RESET = 31;
	localparam int HMC_BIT_OC_METHOD = 15;
	localparam int HMC_BIT_BUS_WIDTH = 8;
	localparam int HMC_BIT_DMA_ACK_POLARITY = 6;
	localparam int HMC_BIT_DMA_REQUEST_POLARITY = 5;
	localparam int HMC_BIT_IRQ_POL = 2;
	localparam int HMC_BIT_IRQ_PULSE = 1;
	localparam int HMC_BIT_IRQ_MASTER = 0;
	localparam logic [31:0] HMC_MODE_WMASK = 32'h8000_8167;
	localparam logic [31:0] HMC_MODE_RESET = 32'h0000_0100;

	// ==========================================================
	// Status and mask fields.
	localparam int HMC_NUM_EVENTS = 4;
	localparam logic [3:0] HMC_EVT_RESET = 4'h0;
	localparam logic [1:0] HMC_RESP_OKAY = 2'b00;
	localparam logic [1:0] HMC_RESP_SLVERR = 2'b10;

	// ==========================================================
	// Timing.
	localparam int HMC_CLK_PERIOD_NS = 100;
	localparam int HMC_PULSE_NS = 400;
	localparam int HMC_PULSE_CYCLES = (HMC_PULSE_NS + HMC_CLK_PERIOD_NS - 1) / HMC_CLK_PERIOD_NS;
	localparam logic [3:0] HMC_PULSE_LOAD = 4'(HMC_PULSE_CYCLES);
	localparam int HMC_SYNC_DEPTH = 3;

	// ==========================================================
	// Carrier types.
	typedef struct packed {
		logic [11:0] awaddr;
		logic        aw_taken;
		logic        awready;
		logic        wready;
		logic        arready;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        w_taken;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} hmc_bus_t;

	typedef struct packed {
		logic [31:0] mode;
		logic [3:0]  status;
		logic [3:0]  mask;
		logic [3:0]  ev_prev;
		logic [3:0]  pulse_cnt;
		logic        irq_prev;
		logic        irq_out;
		logic        dma_request_out_out;
		logic        dma_acknowledge_in_seen;
		logic [2:0]  oc1_sync;
		logic [2:0]  oc2_sync;
		logic [2:0]  oc3_sync;
		logic [2:0]  dma_acknowledge_in_sync;
		logic [2:0]  oc_seen;
	} hmc_core_t;

	typedef struct packed {
		hmc_bus_t  bus;
		hmc_core_t core;
	} hmc_state_t;

endpackage

//--- verilog/hmc_mode_regs.sv
// Hardware mode control register bank with AXI4-Lite slave and interrupt output stage.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
// ==========================================================
// Function
// - Bit 31 written 1 holds all transceivers in debug reset; 0 releases.
// - Bit 15 picks digital (0) or analog (1) overcurrent detection.
// - Bit 8 picks a 16-bit (0) or 32-bit (1) data bus.
// - Bit 6 sets DMA acknowledge input polarity, 1 active high.
// - Bit 5 sets DMA request output polarity, 1 active high.
// - Bit 2 sets interrupt polarity; bit 1 picks level or fixed pulse.
// - With bit 0 clear the interrupt output is deasserted from the next cycle on.
// - With bit 0 set, enabled pending events assert the interrupt output.
module hmc_mode_regs
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [3:0]  irq_events,
	input  wire logic        port1_overcurrent_in,
	input  wire logic        port2_overcurrent_in,
	input  wire logic        port3_overcurrent_in,
	input  wire logic        dma_acknowledge_in,
	input  wire logic        dma_request_int,
	output logic             dma_request_out,
	output logic             irq_out,
	output logic             transceivers_debug_reset,
	output logic             overcurrent_method_select,
	output logic             bus_width_32,
	output logic             dma_ack_active,
	output logic [2:0]       port_overcurrent
);

	hmc_pkg::hmc_state_t state_reg;
	hmc_pkg::hmc_state_t state_next;
	logic [31:0]         merged;
	logic                w_fire;
	logic                irq_want;
	logic                dma_acknowledge_in_raw;

	// ==========================================================
	// Byte lane merge.
	function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Change counts once second and third stage agree.
	function automatic logic sync_val(input logic [2:0] s, input logic held);
		return (s[1] == s[2]) ? s[2] : held;
	endfunction

	// ==========================================================
	// Next state.
	always_comb
	begin
		state_next = state_reg;
		merged = 32'h0000_0000;
		irq_want = 1'b0;
		dma_acknowledge_in_raw = 1'b0;
		w_fire = 1'b0;
		// Address and data are taken independently, in either order.
		if (s_axi_awvalid && !state_reg.bus.aw_taken && !state_reg.bus.bvalid)
		begin
			state_next.bus.awaddr = s_axi_awaddr;
			state_next.bus.aw_taken = 1'b1;
		end
		if (s_axi_wvalid && !state_reg.bus.w_taken && !state_reg.bus.bvalid)
		begin
			state_next.bus.wdata = s_axi_wdata;
			state_next.bus.wstrb = s_axi_wstrb;
			state_next.bus.w_taken = 1'b1;
		end
		// Events set sticky status bits; a set beats a concurrent clear.
		state_next.core.ev_prev = irq_events;
		w_fire = state_reg.bus.aw_taken && state_reg.bus.w_taken && !state_reg.bus.bvalid;
		if (w_fire)
		begin
			state_next.bus.aw_taken = 1'b0;
			state_next.bus.w_taken = 1'b0;
			state_next.bus.bvalid = 1'b1;
			state_next.bus.bresp = hmc_pkg::HMC_RESP_OKAY;
			unique case (state_reg.bus.awaddr)
				hmc_pkg::HMC_ADDR_MODE:
				begin
					merged = strb_merge(state_reg.core.mode, state_reg.bus.wdata,
						state_reg.bus.wstrb);
					// Reserved bits are not stored and read back as zero.
					state_next.core.mode = merged & hmc_pkg::HMC_MODE_WMASK;
				end
				hmc_pkg::HMC_ADDR_IRQ_STATUS:
				begin
					merged = strb_merge(32'h0000_0000, state_reg.bus.wdata, state_reg.bus.wstrb);
					state_next.core.status = state_reg.core.status & ~merged[3:0];
				end
				hmc_pkg::HMC_ADDR_IRQ_MASK:
				begin
					merged = strb_merge({28'h000_0000, state_reg.core.mask},
						state_reg.bus.wdata, state_reg.bus.wstrb);
					state_next.core.mask = merged[3:0];
				end
				hmc_pkg::HMC_ADDR_STATE:
				begin
					state_next.bus.bresp = hmc_pkg::HMC_RESP_OKAY;
				end
				default:
				begin
					state_next.bus.bresp = hmc_pkg::HMC_RESP_SLVERR;
				end
			endcase
		end
		state_next.core.status = state_next.core.status | (irq_events & ~state_reg.core.ev_prev);
		if (state_reg.bus.bvalid && s_axi_bready)
		begin
			state_next.bus.bvalid = 1'b0;
		end
		// Read channel.
		if (s_axi_arvalid && !state_reg.bus.rvalid)
		begin
			state_next.bus.rvalid = 1'b1;
			state_next.bus.rresp = hmc_pkg::HMC_RESP_OKAY;
			unique case (s_axi_araddr)
				hmc_pkg::HMC_ADDR_MODE:
					state_next.bus.rdata = state_reg.core.mode;
				hmc_pkg::HMC_ADDR_IRQ_STATUS:
					state_next.bus.rdata = {28'h000_0000, state_reg.core.status};
				hmc_pkg::HMC_ADDR_IRQ_MASK:
					state_next.bus.rdata = {28'h000_0000, state_reg.core.mask};
				hmc_pkg::HMC_ADDR_STATE:
					state_next.bus.rdata = {27'h000_0000, state_reg.core.dma_acknowledge_in_seen,
						state_reg.core.oc_seen, state_reg.core.irq_prev};
				default:
				begin
					state_next.bus.rdata = 32'h0000_0000;
					state_next.bus.rresp = hmc_pkg::HMC_RESP_SLVERR;
				end
			endcase
		end
		else if (state_reg.bus.rvalid && s_axi_rready)
		begin
			state_next.bus.rvalid = 1'b0;
		end
		state_next.bus.awready = !state_next.bus.aw_taken && !state_next.bus.bvalid;
		state_next.bus.wready = !state_next.bus.w_taken && !state_next.bus.bvalid;
		state_next.bus.arready = !state_next.bus.rvalid;
		// Pin inputs pass three flip-flops.
		state_next.core.oc1_sync = {state_reg.core.oc1_sync[1:0], port1_overcurrent_in};
		state_next.core.oc2_sync = {state_reg.core.oc2_sync[1:0], port2_overcurrent_in};
		state_next.core.oc3_sync = {state_reg.core.oc3_sync[1:0], port3_overcurrent_in};
		state_next.core.dma_acknowledge_in_sync = {state_reg.core.dma_acknowledge_in_sync[1:0], dma_acknowledge_in};
		state_next.core.oc_seen[0] = sync_val(state_reg.core.oc1_sync, state_reg.core.oc_seen[0]);
		state_next.core.oc_seen[1] = sync_val(state_reg.core.oc2_sync, state_reg.core.oc_seen[1]);
		state_next.core.oc_seen[2] = sync_val(state_reg.core.oc3_sync, state_reg.core.oc_seen[2]);
		dma_acknowledge_in_raw = sync_val(state_reg.core.dma_acknowledge_in_sync, state_reg.core.dma_acknowledge_in_seen ^
			~state_reg.core.mode[hmc_pkg::HMC_BIT_DMA_ACK_POLARITY]);
		state_next.core.dma_acknowledge_in_seen = dma_acknowledge_in_raw ^ ~state_reg.core.mode[hmc_pkg::HMC_BIT_DMA_ACK_POLARITY];
		// DMA request output polarity.
		state_next.core.dma_request_out_out = dma_request_int ^ ~state_reg.core.mode[hmc_pkg::HMC_BIT_DMA_REQUEST_POLARITY];
		// Interrupt: masked events, gated by the master enable.
		irq_want = state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_MASTER] &&
			|(state_reg.core.status & state_reg.core.mask);
		state_next.core.irq_prev = irq_want;
		if (!state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_MASTER])
		begin
			state_next.core.pulse_cnt = 4'h0;
		end
		else if (irq_want && !state_reg.core.irq_prev)
		begin
			state_next.core.pulse_cnt = hmc_pkg::HMC_PULSE_LOAD;
		end
		else if (state_reg.core.pulse_cnt != 4'h0)
		begin
			state_next.core.pulse_cnt = state_reg.core.pulse_cnt - 4'h1;
		end
		if (state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_PULSE])
		begin
			state_next.core.irq_out = (state_next.core.pulse_cnt != 4'h0) ^
				~state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_POL];
		end
		else
		begin
			state_next.core.irq_out = irq_want ^ ~state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_POL];
		end
	end

	// ==========================================================
	// State register.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
			state_reg.core.mode <= hmc_pkg::HMC_MODE_RESET;
			state_reg.core.irq_out <= 1'b1;
			state_reg.core.dma_request_out_out <= 1'b1;
			state_reg.bus.awready <= 1'b1;
			state_reg.bus.wready <= 1'b1;
			state_reg.bus.arready <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs, each straight from the state register.
	assign s_axi_awready = state_reg.bus.awready;
	assign s_axi_wready = state_reg.bus.wready;
	assign s_axi_bvalid = state_reg.bus.bvalid;
	assign s_axi_bresp = state_reg.bus.bresp;
	assign s_axi_arready = state_reg.bus.arready;
	assign s_axi_rvalid = state_reg.bus.rvalid;
	assign s_axi_rdata = state_reg.bus.rdata;
	assign s_axi_rresp = state_reg.bus.rresp;
	assign irq_out = state_reg.core.irq_out;
	assign dma_request_out = state_reg.core.dma_request_out_out;
	assign transceivers_debug_reset = state_reg.core.mode[hmc_pkg::HMC_BIT_XCVR_RESET];
	assign overcurrent_method_select = state_reg.core.mode[hmc_pkg::HMC_BIT_OC_METHOD];
	assign bus_width_32 = state_reg.core.mode[hmc_pkg::HMC_BIT_BUS_WIDTH];
	assign dma_ack_active = state_reg.core.dma_acknowledge_in_seen;
	assign port_overcurrent = state_reg.core.oc_seen;

	// ==========================================================
	// Assertions.
	a_irq_master_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_MASTER] ##1
		!state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_MASTER] |->
		irq_out == ~$past(state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_POL]))
		else $error("Interrupt asserted while master enable is off.");
	a_irq_level_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
		irq_want && !state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_PULSE] &&
		$stable(state_reg.core.mode)
		|=> irq_out == $past(state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_POL]))
		else $error("Level interrupt not asserted for a pending enabled event.");
	a_irq_pulse_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
		irq_want && !state_reg.core.irq_prev && state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_PULSE]
		|=> state_reg.core.pulse_cnt == hmc_pkg::HMC_PULSE_LOAD)
		else $error("Interrupt pulse not started with its full width.");
	a_pulse_countdown: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg.core.pulse_cnt != 4'h0 && state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_MASTER] &&
		!(irq_want && !state_reg.core.irq_prev)
		|=> state_reg.core.pulse_cnt == $past(state_reg.core.pulse_cnt) - 4'h1)
		else $error("Interrupt pulse width counter skipped a step.");
	a_xcvr_reset_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		w_fire && state_reg.bus.awaddr == hmc_pkg::HMC_ADDR_MODE && &state_reg.bus.wstrb |=>
		transceivers_debug_reset == $past(state_reg.bus.wdata[hmc_pkg::HMC_BIT_XCVR_RESET]))
		else $error("Transceiver reset does not follow bit 31.");
	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg.core.mode & ~hmc_pkg::HMC_MODE_WMASK) == 32'h0000_0000)
		else $error("Reserved mode bits hold ones.");
	a_dma_request_out_polarity: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$stable(state_reg.core.mode) |=> dma_request_out == ($past(dma_request_int) ^
		~$past(state_reg.core.mode[hmc_pkg::HMC_BIT_DMA_REQUEST_POLARITY])))
		else $error("DMA request polarity wrong.");
	a_oc_method: assert property (@(posedge sys_clk) disable iff (!rst_n)
		w_fire && state_reg.bus.awaddr == hmc_pkg::HMC_ADDR_MODE && &state_reg.bus.wstrb |=>
		overcurrent_method_select == $past(state_reg.bus.wdata[hmc_pkg::HMC_BIT_OC_METHOD]))
		else $error("Overcurrent method select does not follow bit 15.");
	a_bus_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
		w_fire && state_reg.bus.awaddr == hmc_pkg::HMC_ADDR_MODE && &state_reg.bus.wstrb |=>
		bus_width_32 == $past(state_reg.bus.wdata[hmc_pkg::HMC_BIT_BUS_WIDTH]))
		else $error("Bus width does not follow bit 8.");
	a_dma_acknowledge_in_polarity: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg.core.dma_acknowledge_in_sync[2] == state_reg.core.dma_acknowledge_in_sync[1] && $stable(state_reg.core.mode)
		|=> dma_ack_active == ($past(state_reg.core.dma_acknowledge_in_sync[2]) ^
		~$past(state_reg.core.mode[hmc_pkg::HMC_BIT_DMA_ACK_POLARITY])))
		else $error("DMA acknowledge polarity wrong.");
	a_event_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
		|(irq_events & ~state_reg.core.ev_prev) |=>
		(state_reg.core.status & $past(irq_events) & ~$past(state_reg.core.ev_prev)) ==
		($past(irq_events) & ~$past(state_reg.core.ev_prev)))
		else $error("Interrupt event lost its sticky status bit.");

	// ==========================================================
	// Cover properties.
	c_write_mode: cover property (@(posedge sys_clk) disable iff (!rst_n)
		w_fire && state_reg.bus.awaddr == hmc_pkg::HMC_ADDR_MODE);
	c_irq_pulse: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg.core.pulse_cnt == hmc_pkg::HMC_PULSE_LOAD);
	c_irq_level: cover property (@(posedge sys_clk) disable iff (!rst_n)
		irq_want && !state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_PULSE]);
	c_set_and_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
		w_fire && state_reg.bus.awaddr == hmc_pkg::HMC_ADDR_IRQ_STATUS &&
		|(irq_events & ~state_reg.core.ev_prev));
	c_master_gate: cover property (@(posedge sys_clk) disable iff (!rst_n)
		!state_reg.core.mode[hmc_pkg::HMC_BIT_IRQ_MASTER] && |(state_reg.core.status & state_reg.core.mask));

endmodule

//--- tb/hmc_host_model.sv
// Host processor model that reaches the register bank over AXI4-Lite.
`timescale 1ns/1ps
module hmc_host_model
(
	input  wire logic        sys_clk,
	output logic [11:0]      s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [11:0]      s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready,
	output logic             hung
);
	// ==========================================================
	// Idle bus at time zero.
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hung} = 6'h00;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h0;
	end

	// ==========================================================
	// One write; address and data offered together, each held until taken.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid && n < 64);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (!s_axi_bvalid)
			hung <= 1'b1;
	endtask

	// ==========================================================
	// One read; address held until taken, data taken with rvalid.
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid && n < 64);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (!s_axi_rvalid)
			hung <= 1'b1;
	endtask
endmodule

//--- tb/tb_top.sv
// Self-checking testbench of the mode register bank.
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, port1_overcurrent_in, port2_overcurrent_in, port3_overcurrent_in;
	logic        dma_acknowledge_in, dma_request_int, dma_request_out, irq_out, hung;
	logic        transceivers_debug_reset, overcurrent_method_select, bus_width_32, dma_ack_active;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, m, rn;
	logic [3:0]  s_axi_wstrb, irq_events;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [2:0]  port_overcurrent;
	int          fails, compares, i, n;
	int          seed;

	hmc_mode_regs dut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq_events, .port1_overcurrent_in, .port2_overcurrent_in,
		.port3_overcurrent_in, .dma_acknowledge_in, .dma_request_int, .dma_request_out, .irq_out,
		.transceivers_debug_reset, .overcurrent_method_select, .bus_width_32, .dma_ack_active,
		.port_overcurrent);

	hmc_host_model host (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .hung);

	// ==========================================================
	// Clock, comparison, expectations and closing report.
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic dma_request_out_exp(input logic [31:0] md, input logic req);
		return md[5] ? req : ~req;
	endfunction

	task automatic results;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge hung)
	begin
		fails++;
		results();
	end

	// ==========================================================
	// Main sequence.
	initial
	begin
		seed = 32'h2ac4_b4a2;
		{fails, compares} = 0;
		{rst_n, dma_acknowledge_in, dma_request_int} = 3'b000;
		{port1_overcurrent_in, port2_overcurrent_in, port3_overcurrent_in} = 3'b000;
		irq_events = 4'h0;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		host.rd(hmc_pkg::HMC_ADDR_MODE, d, r);
		chk(d, 32'h0000_0100);
		chk(bus_width_32, 1'b1);
		chk(irq_out, 1'b1);
		$display("test reset values done");
		for (i = 0; i < 16; i++)
		begin
			m = $random(seed) & hmc_pkg::HMC_MODE_WMASK;
			host.wr(hmc_pkg::HMC_ADDR_MODE, m, r);
			rn = $random(seed);
			{port3_overcurrent_in, port2_overcurrent_in, port1_overcurrent_in} <= rn[2:0];
			dma_acknowledge_in <= rn[3];
			dma_request_int <= rn[4];
			host.rd(hmc_pkg::HMC_ADDR_MODE, d, r);
			chk(d, m);
			repeat (6) @(posedge sys_clk);
			chk(transceivers_debug_reset, m[31]);
			chk(overcurrent_method_select, m[15]);
			chk(bus_width_32, m[8]);
			chk(dma_ack_active, rn[3] == m[6]);
			chk(dma_request_out, dma_request_out_exp(m, rn[4]));
			chk(irq_out, !m[2]);
			chk(port_overcurrent, rn[2:0]);
			host.wr(hmc_pkg::HMC_ADDR_MODE, m & 32'h7fff_ffff, r);
			repeat (2) @(posedge sys_clk);
			chk(transceivers_debug_reset, 1'b0);
		end
		$display("test mode fields done");
		host.wr(hmc_pkg::HMC_ADDR_IRQ_MASK, 32'h0000_0001, r);
		host.wr(hmc_pkg::HMC_ADDR_MODE, 32'h0000_0004, r);
		irq_events <= 4'h1;
		repeat (6) @(posedge sys_clk);
		chk(irq_out, 1'b0);
		host.rd(hmc_pkg::HMC_ADDR_IRQ_STATUS, d, r);
		chk(d, 32'h0000_0001);
		host.wr(hmc_pkg::HMC_ADDR_MODE, 32'h0000_0005, r);
		repeat (4) @(posedge sys_clk);
		chk(irq_out, 1'b1);
		host.wr(hmc_pkg::HMC_ADDR_IRQ_MASK, 32'h0000_0000, r);
		repeat (4) @(posedge sys_clk);
		chk(irq_out, 1'b0);
		host.wr(hmc_pkg::HMC_ADDR_IRQ_MASK, 32'h0000_000f, r);
		irq_events <= 4'h0;
		host.wr(hmc_pkg::HMC_ADDR_IRQ_STATUS, 32'h0000_0001, r);
		repeat (4) @(posedge sys_clk);
		chk(irq_out, 1'b0);
		host.wr(hmc_pkg::HMC_ADDR_MODE, 32'h0000_0003, r);
		irq_events <= 4'h2;
		n = 0;
		repeat (20)
		begin
			@(posedge sys_clk);
			n += (irq_out === 1'b0);
		end
		chk(n, hmc_pkg::HMC_PULSE_CYCLES);
		irq_events <= 4'h0;
		$display("test interrupt done");
		host.rd(12'h304, d, r);
		chk(r, hmc_pkg::HMC_RESP_SLVERR);
		chk(d, 32'h0000_0000);
		host.wr(12'h304, 32'hffff_ffff, r);
		chk(r, hmc_pkg::HMC_RESP_SLVERR);
		host.rd(hmc_pkg::HMC_ADDR_MODE, d, r);
		chk(d, 32'h0000_0003);
		$display("test unmapped done");
		host.rd(hmc_pkg::HMC_ADDR_STATE, d, r);
		chk(d, {27'h000_0000, !rn[3], rn[2:0], 1'b1});
		host.wr(hmc_pkg::HMC_ADDR_STATE, 32'hffff_ffff, r);
		chk(r, hmc_pkg::HMC_RESP_OKAY);
		host.rd(hmc_pkg::HMC_ADDR_MODE, d, r);
		chk(d, 32'h0000_0003);
		$display("test state register done");
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		host.rd(hmc_pkg::HMC_ADDR_MODE, d, r);
		chk(d, 32'h0000_0100);
		chk(irq_out, 1'b1);
		host.rd(hmc_pkg::HMC_ADDR_IRQ_STATUS, d, r);
		chk(d, 32'h0000_0000);
		$display("test second reset done");
		results();
	end
endmodule
